// File: vads_pkg.sv
// package: constants, types and register map of the attribute dot serializer
package vads_pkg;
  // ----------------------------------------------------------------
  // clocking and rates
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DOT_MAX_MHZ = 20;
  localparam int CHAR_MAX_KHZ = 2500;
  localparam int DOT_DIV = (CLK_MHZ + DOT_MAX_MHZ - 1) / DOT_MAX_MHZ;
  localparam int LOAD_MIN_CYCLES = (CLK_MHZ * 1000 + CHAR_MAX_KHZ - 1) / CHAR_MAX_KHZ;
  localparam int VSYNC_HZ = 60;
  localparam int BLINK_DIV = 32;
  localparam int BLINK_W = $clog2(BLINK_DIV);
  // ----------------------------------------------------------------
  // cell geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] UL_ROW_STD = 4'h0b;
  localparam logic [3:0] UL_ROW_RED = 4'h8;
  localparam logic [3:0] STK_ROW_STD_A = 4'h5;
  localparam logic [3:0] STK_ROW_STD_B = 4'h6;
  localparam logic [3:0] STK_ROW_RED = 4'h4;
  localparam logic [3:0] BAND_ROWS_STD = 4'h3;
  localparam logic [3:0] BAND_ROWS_RED = 4'h4;
  localparam logic [3:0] THIN_MID_ROW = 4'h5;
  localparam logic [7:0] THIN_VERT_MASK = 8'h08;
  localparam logic [7:0] LEFT_HALF = 8'hf0;
  localparam logic [7:0] RIGHT_HALF = 8'h0f;
  localparam logic [7:0] ALL_DOTS = 8'hff;
  localparam logic [7:0] NO_DOTS = 8'h00;
  // ----------------------------------------------------------------
  // register map (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_BLINK = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_VIDEO_EN = 0;
  localparam int ST_CHAR_OFF = 0;
  localparam int ST_CURSOR_ON = 1;
  localparam int ST_BUF_FULL = 2;
  localparam int ST_RATE_ERR = 3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {VADS_WIDE, VADS_CHAR, VADS_THIN} vads_mode_t;
  typedef struct packed {
    logic inverseVideo;
    logic cellBlanking;
    logic underscoreLine;
    logic strikeLine;
    logic blinkAttr;
    logic modeSelectHigh;
    logic modeSelectLow;
  } vads_attr_t;
  typedef struct packed {
    logic [7:0] dots;
    logic fill;
  } vads_pattern_t;
endpackage

// File: vads_pair_buffer.sv
// small valid/ready buffer between pattern composer and serializer
`timescale 1ns/1ps
`default_nettype none
module vads_pair_buffer
  import vads_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic doPush;
  logic doPop;

  // handshake terms
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign outData = mem[rdPtr_q];

  // storage write
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule // vads_pair_buffer
`default_nettype wire

// File: vads_top.sv
// attribute dot serializer: latches, attribute logic, blink, shifter, bus slave
`timescale 1ns/1ps
`default_nettype none
module vads_top
  import vads_pkg::*;
#(
  parameter int DOT_DIVIDE = DOT_DIV,
  parameter bit REDUCED = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic loadShiftSelect,
  input wire logic [7:0] charCodeBus,
  input wire logic [3:0] rowAddress,
  input wire logic attributeLatchStrobeEnable,
  input wire logic inverseVideo,
  input wire logic cellBlanking,
  input wire logic underscoreLine,
  input wire logic strikeLine,
  input wire logic blinkAttr,
  input wire logic modeSelectHigh,
  input wire logic modeSelectLow,
  input wire logic cursorEnable,
  input wire logic retraceBlanking,
  input wire logic verticalSync,
  output logic videoOut
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PINS = 24;
  logic [PINS-1:0] pinRaw, pinMeta_q, pinSync_q;
  assign pinRaw = {loadShiftSelect, verticalSync, retraceBlanking, cursorEnable,
                   attributeLatchStrobeEnable, inverseVideo, cellBlanking, underscoreLine,
                   strikeLine, blinkAttr, modeSelectHigh, modeSelectLow, rowAddress,
                   charCodeBus};
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_sync
      // two flops per pin, first one read only by the second
      always_ff @(posedge clk) begin
        pinMeta_q[gi] <= pinRaw[gi];
        pinSync_q[gi] <= pinMeta_q[gi];
      end
    end
  endgenerate
  logic lsSync, vsSync, retSync, curSync, strobeSync;
  vads_attr_t attrSync;
  logic [3:0] rowSync;
  logic [7:0] codeSync;
  assign {lsSync, vsSync, retSync, curSync, strobeSync, attrSync, rowSync, codeSync} = pinSync_q;
  // register and buffer state read ahead of the sections that drive it
  logic [31:0] ctrl_q, readData_q;
  logic rateErr_q, busAck_q, busReq, bufInReady, bufOutValid, wrAck;
  logic [BLINK_W-1:0] blinkCnt_q;

  // ----------------------------------------------------------------
  // dot rate divider
  // ----------------------------------------------------------------
  logic [7:0] divCnt_q, sinceLoad_q;
  logic dotEn;
  assign dotEn = (divCnt_q == 8'(DOT_DIVIDE - 1));
  // one enable pulse every DOT_DIVIDE clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= dotEn ? '0 : divCnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // load edge detect and latches
  // ----------------------------------------------------------------
  logic lsPrev_q, lsFall, retrace_q, cursor_q;
  logic [7:0] code_q;
  logic [3:0] row_q;
  vads_attr_t attr_q;
  assign lsFall = lsPrev_q && !lsSync;
  // code, row, retrace and cursor caught on falling load edge
  always_ff @(posedge clk) begin
    if (reset) begin
      lsPrev_q <= 1'b0;
      code_q <= '0;
      row_q <= '0;
      retrace_q <= 1'b1;
      cursor_q <= 1'b0;
    end else begin
      lsPrev_q <= lsSync;
      if (lsFall) begin
        code_q <= codeSync;
        row_q <= rowSync;
        retrace_q <= retSync;
        cursor_q <= curSync;
      end
    end
  end
  // attribute latch, held while strobe enable is low
  always_ff @(posedge clk) begin
    if (reset) begin
      attr_q <= '0;
    end else if (lsFall && strobeSync) begin
      attr_q <= attrSync;
    end
  end

  // ----------------------------------------------------------------
  // blink dividers on vertical sync
  // ----------------------------------------------------------------
  logic vsPrev_q, vsTick, charOff, cursorOn, lineRow;
  assign vsTick = vsSync && !vsPrev_q;
  assign charOff = (blinkCnt_q[BLINK_W-1 -: 2] == 2'b11);
  assign cursorOn = blinkCnt_q[BLINK_W-2];
  always_ff @(posedge clk) begin
    if (reset) begin
      vsPrev_q <= 1'b0;
      blinkCnt_q <= '0;
    end else begin
      vsPrev_q <= vsSync;
      if (vsTick) begin
        blinkCnt_q <= blinkCnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // attribute logic and graphics
  // ----------------------------------------------------------------
  function automatic logic onRow(input logic [3:0] row, input logic [3:0] target);
    return row == target;
  endfunction
  vads_mode_t mode;
  logic [3:0] band;
  logic [7:0] glyph;
  vads_pattern_t pattern;
  always_comb begin
    // mode is taken from the latched attributes of this character
    case ({attr_q.modeSelectHigh, attr_q.modeSelectLow})
      2'b00: mode = VADS_WIDE;
      2'b10: mode = VADS_THIN;
      default: mode = VADS_CHAR;
    endcase
    band = row_q / (REDUCED ? BAND_ROWS_RED : BAND_ROWS_STD);
    case (mode)
      VADS_WIDE: begin
        // two columns per band, a segment per code bit
        glyph = (code_q[{band[1:0], 1'b0}] ? LEFT_HALF : NO_DOTS)
              | (code_q[{band[1:0], 1'b1}] ? RIGHT_HALF : NO_DOTS);
        if (REDUCED && band > 4'h2) begin
          glyph = NO_DOTS;
        end
      end
      VADS_THIN: begin
        glyph = NO_DOTS;
        if (code_q[0] && onRow(row_q, THIN_MID_ROW)) glyph = ALL_DOTS;
        if (code_q[1] && row_q <= THIN_MID_ROW) glyph = glyph | THIN_VERT_MASK;
        if (code_q[2] && row_q >= THIN_MID_ROW) glyph = glyph | THIN_VERT_MASK;
      end
      default: glyph = code_q;
    endcase
    // underline and strike rows, each from its own attribute
    lineRow = (attr_q.underscoreLine &&
               onRow(row_q, REDUCED ? UL_ROW_RED : UL_ROW_STD))
            || (attr_q.strikeLine && (REDUCED ? onRow(row_q, STK_ROW_RED)
               : (onRow(row_q, STK_ROW_STD_A) || onRow(row_q, STK_ROW_STD_B))));
    if (lineRow) glyph = ALL_DOTS;
    if (attr_q.cellBlanking || (attr_q.blinkAttr && charOff)) glyph = NO_DOTS;
    pattern.dots = glyph;
    pattern.fill = 1'b0;
    if (attr_q.inverseVideo ^ (cursor_q && cursorOn)) begin
      pattern.dots = ~glyph;
      pattern.fill = 1'b1;
    end
    if (retrace_q) begin
      pattern.dots = NO_DOTS;
      pattern.fill = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // composed pattern waits for the buffer
  // ----------------------------------------------------------------
  logic compose_q, pendValid_q, bufPop;
  vads_pattern_t pend_q, bufOut;
  always_ff @(posedge clk) begin
    if (reset) begin
      compose_q <= 1'b0;
      pendValid_q <= 1'b0;
      pend_q <= '0;
    end else begin
      compose_q <= lsFall;
      if (compose_q) begin
        pend_q <= pattern;
        pendValid_q <= 1'b1;
      end else if (pendValid_q && bufInReady) begin
        pendValid_q <= 1'b0;
      end
    end
  end
  vads_pair_buffer #(.WIDTH($bits(vads_pattern_t)), .DEPTH(2)) u_buf (
    .clk(clk), .reset(reset), .inData(pend_q), .inValid(pendValid_q && !compose_q),
    .inReady(bufInReady), .outData(bufOut), .outValid(bufOutValid), .outReady(bufPop)
  );

  // ----------------------------------------------------------------
  // serializer
  // ----------------------------------------------------------------
  logic [7:0] shift_q;
  logic fill_q, loaded_q, doLoad;
  assign doLoad = dotEn && lsSync && !loaded_q;
  assign bufPop = doLoad && bufOutValid;
  // parallel load once per high load level, shift one dot while load is low
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_q <= '0;
      fill_q <= 1'b0;
      loaded_q <= 1'b0;
    end else if (dotEn) begin
      if (doLoad) begin
        shift_q <= bufOutValid ? bufOut.dots : NO_DOTS;
        fill_q <= bufOutValid ? bufOut.fill : 1'b0;
        loaded_q <= 1'b1;
      end else if (!lsSync) begin
        shift_q <= {shift_q[6:0], fill_q};
        loaded_q <= 1'b0;
      end
    end
  end
  // video pin from a flop, gated by software enable
  always_ff @(posedge clk) begin
    videoOut <= !reset && shift_q[7] && ctrl_q[CTRL_VIDEO_EN];
  end

  // ----------------------------------------------------------------
  // character rate watch
  // ----------------------------------------------------------------
  // counts up from each load fall; starts saturated so the first load is never early
  always_ff @(posedge clk) begin
    if (reset) begin
      sinceLoad_q <= 8'(LOAD_MIN_CYCLES);
    end else if (lsFall) begin
      sinceLoad_q <= '0;
    end else if (sinceLoad_q != 8'(LOAD_MIN_CYCLES)) begin
      sinceLoad_q <= sinceLoad_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  assign busReq = avs_read || avs_write;
  assign avs_waitrequest = busReq && !busAck_q;
  assign avs_readdata = readData_q;
  assign wrAck = avs_write && busAck_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      busAck_q <= 1'b0;
      readData_q <= '0;
      ctrl_q <= CTRL_RESET;
    end else begin
      busAck_q <= busReq && !busAck_q;
      if (avs_read && !busAck_q) begin
        case (avs_address)
          REG_CTRL: readData_q <= ctrl_q;
          REG_STATUS: readData_q <= {28'h000_0000, rateErr_q, !bufInReady, cursorOn, charOff};
          REG_BLINK: readData_q <= 32'(blinkCnt_q);
          default: readData_q <= '0;
        endcase
      end
      if (wrAck && avs_address == REG_CTRL) begin
        ctrl_q <= avs_writedata;
      end
    end
  end
  // sticky rate error; a new violation wins over the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      rateErr_q <= 1'b0;
    end else if (lsFall && sinceLoad_q < 8'(LOAD_MIN_CYCLES - 1)) begin
      rateErr_q <= 1'b1;
    end else if (wrAck && avs_address == REG_STATUS && avs_writedata[ST_RATE_ERR]) begin
      rateErr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_load;
    dotEn && lsSync && !loaded_q && bufOutValid;
  endsequence
  a_retrace_zero: assert property (compose_q && retrace_q |=> pend_q == '0)
    else $error("retrace pattern not zero");
  a_dot_single: assert property (dotEn |=> !dotEn)
    else $error("dot enable longer than one cycle");
  a_dot_shift: assert property (dotEn && !lsSync |=> shift_q == {$past(shift_q[6:0]), $past(fill_q)})
    else $error("shift step wrong");
  a_load_pattern: assert property (s_load |=> shift_q == $past(bufOut.dots) && loaded_q)
    else $error("parallel load wrong");
  a_attr_hold: assert property (lsFall && !strobeSync |=> $stable(attr_q))
    else $error("attributes changed without strobe");
  a_blink_duty: assert property (vsTick && blinkCnt_q == 5'h17 |=> charOff)
    else $error("char blink off phase missing");
  a_cursor_rate: assert property (vsTick && blinkCnt_q == 5'h07 |=> cursorOn && !charOff)
    else $error("cursor phase wrong");
  a_blank_cell: assert property (compose_q && !retrace_q && attr_q.cellBlanking
      && !attr_q.inverseVideo && !cursor_q |=> pend_q.dots == NO_DOTS)
    else $error("blanked cell shows dots");
  a_bus_answer: assert property (busReq && !busAck_q |=> !avs_waitrequest || !busReq)
    else $error("bus answer late");
endmodule // vads_top
`default_nettype wire

// File: vads_ctl_model.sv
// partner model: timing controller and font memory feeding the serializer pins
`timescale 1ns/1ps
`default_nettype none
module vads_ctl_model
  import vads_pkg::*;
#(
  parameter int DIV = DOT_DIV
) (
  input wire logic clk,
  output logic loadShiftSelect,
  output logic [7:0] charCodeBus,
  output logic [3:0] rowAddress,
  output var vads_attr_t attr,
  output logic strobeEnable,
  output logic cursorEnable,
  output logic retraceBlanking,
  output logic verticalSync,
  input wire logic videoOut
);
  int phase = 0;
  logic seen [0:59];

  // pins idle at time zero
  initial begin
    {loadShiftSelect, charCodeBus, rowAddress, attr} = '0;
    {strobeEnable, cursorEnable, retraceBlanking, verticalSync} = '0;
  end

  // free-running phase keeps every slot on the same dot boundary
  always @(posedge clk) begin
    phase <= (phase == DIV - 1) ? 0 : phase + 1;
  end

  // one character time: pins and load rise together, load falls after highLen
  task automatic run_slot(input logic [7:0] code, input logic [3:0] row,
      input logic [6:0] a, input logic [2:0] f, input int highLen, input int len);
    int i;
    @(posedge clk);
    while (phase != 0) @(posedge clk);
    loadShiftSelect <= 1'b1;
    charCodeBus <= code;
    rowAddress <= row;
    attr <= vads_attr_t'(a);
    {strobeEnable, cursorEnable, retraceBlanking} <= f;
    for (i = 0; i < len; i++) begin
      @(posedge clk);
      if (i == highLen - 1) loadShiftSelect <= 1'b0;
      seen[i] = videoOut;
    end
  endtask

  // vertical sync pulses step both blink dividers
  task automatic pulse_vsync(input int n);
    repeat (n) begin
      @(posedge clk);
      verticalSync <= 1'b1;
      repeat (4) @(posedge clk);
      verticalSync <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule // vads_ctl_model
`default_nettype wire

// File: tb.sv
// testbench: pin traffic and register bus checks of the attribute dot serializer
`timescale 1ns/1ps
`default_nettype none
module tb
  import vads_pkg::*;
;
  // ----------------------------------------------------------------
  // attribute sets {inverse, blank, underline, strike, blink, msHigh, msLow}
  // ----------------------------------------------------------------
  localparam logic [6:0] WIDE = 7'h00;
  localparam logic [6:0] CHR = 7'h01;
  localparam logic [6:0] THIN = 7'h02;
  localparam logic [6:0] BLNK = 7'h04;
  localparam logic [6:0] STK = 7'h08;
  localparam logic [6:0] UL = 7'h10;
  localparam logic [6:0] BLANK = 7'h20;
  localparam logic [6:0] INV = 7'h40;
  localparam logic [2:0] NORM = 3'h4; // strobe on, no cursor, no retrace
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0000_0000;
  logic [31:0] avsReaddata;
  logic [31:0] rv;
  logic avsWaitrequest, loadShiftSelect, strobeEnable, cursorEnable;
  logic retraceBlanking, verticalSync, videoOut;
  logic [7:0] charCodeBus;
  logic [3:0] rowAddress;
  vads_attr_t attr;
  int fails = 0;
  int cmpCount = 0;
  int calOff = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // device under test
  vads_top #(.DOT_DIVIDE(DOT_DIV), .REDUCED(1'b0)) DUT (
    .clk(clk), .reset(reset), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .loadShiftSelect(loadShiftSelect),
    .charCodeBus(charCodeBus), .rowAddress(rowAddress),
    .attributeLatchStrobeEnable(strobeEnable), .inverseVideo(attr.inverseVideo),
    .cellBlanking(attr.cellBlanking), .underscoreLine(attr.underscoreLine),
    .strikeLine(attr.strikeLine), .blinkAttr(attr.blinkAttr),
    .modeSelectHigh(attr.modeSelectHigh), .modeSelectLow(attr.modeSelectLow),
    .cursorEnable(cursorEnable), .retraceBlanking(retraceBlanking),
    .verticalSync(verticalSync), .videoOut(videoOut)
  );

  // controller and font memory model
  vads_ctl_model #(.DIV(DOT_DIV)) ctl (
    .clk(clk), .loadShiftSelect(loadShiftSelect), .charCodeBus(charCodeBus),
    .rowAddress(rowAddress), .attr(attr), .strobeEnable(strobeEnable),
    .cursorEnable(cursorEnable), .retraceBlanking(retraceBlanking),
    .verticalSync(verticalSync), .videoOut(videoOut)
  );

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    avsAddress <= a;
    avsWritedata <= wd;
    avsWrite <= wr;
    avsRead <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rv = avsReaddata;
    if (n >= 50) fails++;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask

  // register read and compare
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rv, exp);
  endtask

  // send one cell, let the next slot shift it out, compare dots and fill
  task automatic show(input logic [7:0] c, input logic [3:0] r, input logic [6:0] a,
      input logic [2:0] f, input logic [7:0] dots, input logic [1:0] fill);
    vads_pattern_t exp;
    vads_pattern_t got;
    logic [7:0] late;
    int k;
    ctl.run_slot(c, r, a, f, 10, 60);
    ctl.run_slot(8'h00, 4'h0, CHR, NORM, 10, 60);
    for (k = 0; k < 8; k++) begin
      got.dots[7-k] = ctl.seen[calOff + 5*k - 5];
      late[7-k] = ctl.seen[calOff + 5*k - 1];
    end
    got.fill = ctl.seen[calOff + 42];
    exp = '{dots: dots, fill: fill[0]};
    if (fill[1]) got.fill = exp.fill;
    check({23'h00_0000, got}, {23'h00_0000, exp});
    check({24'h00_0000, late}, {24'h00_0000, dots});
  endtask

  // find where the second dot of a shifted cell starts; the first stands while load is high
  task automatic test_calibrate;
    int k;
    calOff = -1;
    ctl.run_slot(8'h40, 4'h0, CHR, NORM, 10, 60);
    ctl.run_slot(8'h00, 4'h0, CHR, NORM, 10, 60);
    for (k = 25; k >= 0; k--) begin
      if (ctl.seen[k] === 1'b1) calOff = k;
    end
    check({31'h0000_0000, calOff >= 5}, 32'h0000_0001);
    if (calOff < 5) calOff = 5;
  endtask

  // reset values, unmapped place, video enable
  task automatic test_registers;
    rdc(REG_CTRL, CTRL_RESET);
    rdc(REG_STATUS, 32'h0000_0000);
    rdc(REG_BLINK, 32'h0000_0000);
    rdc(4'hc, 32'h0000_0000);
    bus(1'b1, 4'hc, 32'h0000_0000);
    rdc(REG_CTRL, CTRL_RESET);
    bus(1'b1, REG_CTRL, 32'h0000_0000);
    show(8'hff, 4'h3, CHR, NORM, 8'h00, 2'h0);
    bus(1'b1, REG_CTRL, 32'h0000_0001);
  endtask

  // wide, thin and character modes mixed per cell
  task automatic test_modes;
    show(8'h01, 4'h0, WIDE, NORM, 8'hf0, 2'h0);
    show(8'hfe, 4'h2, WIDE, NORM, 8'h0f, 2'h0);
    show(8'h04, 4'h3, WIDE, NORM, 8'hf0, 2'h0);
    show(8'h80, 4'hb, WIDE, NORM, 8'h0f, 2'h0);
    show(8'h01, 4'h5, THIN, NORM, 8'hff, 2'h0);
    show(8'h02, 4'h5, THIN, NORM, 8'h08, 2'h0);
    show(8'h04, 4'h4, THIN, NORM, 8'h00, 2'h0);
    show(8'h04, 4'h8, THIN, NORM, 8'h08, 2'h0);
    show(8'ha5, 4'h3, CHR, NORM, 8'ha5, 2'h0);
    show(8'h5a, 4'h3, CHR | THIN, NORM, 8'h5a, 2'h0);
  endtask

  // attribute logic, latch hold and retrace
  task automatic test_attributes;
    show(8'h00, 4'hb, CHR | UL, NORM, 8'hff, 2'h0);
    show(8'h00, 4'ha, CHR | UL, NORM, 8'h00, 2'h0);
    show(8'h00, 4'h6, CHR | STK, NORM, 8'hff, 2'h0);
    show(8'h3c, 4'h7, CHR | STK, NORM, 8'h3c, 2'h0);
    show(8'h3c, 4'h5, CHR | UL, NORM, 8'h3c, 2'h0);
    show(8'h3c, 4'h5, CHR | UL | STK, NORM, 8'hff, 2'h0);
    show(8'h3c, 4'h3, CHR | INV, NORM, 8'hc3, 2'h1);
    show(8'h3c, 4'hb, CHR | INV | UL, NORM, 8'h00, 2'h1);
    show(8'ha5, 4'h3, CHR | BLANK, NORM, 8'h00, 2'h0);
    show(8'ha5, 4'h3, CHR | BLANK | INV, NORM, 8'hff, 2'h1);
    show(8'h01, 4'h0, WIDE | INV, NORM, 8'h0f, 2'h1);
    show(8'h00, 4'hb, THIN | UL, NORM, 8'hff, 2'h0);
    show(8'h3c, 4'h3, WIDE | INV, 3'h0, 8'h3c, 2'h0);
    show(8'ha5, 4'h3, CHR | INV | UL, 3'h5, 8'h00, 2'h2);
  endtask

  // blink dividers stepped by vertical sync
  task automatic test_blink_cursor;
    show(8'ha5, 4'h3, CHR | BLNK, NORM, 8'ha5, 2'h0);
    show(8'h0f, 4'h3, CHR, 3'h6, 8'h0f, 2'h0);
    ctl.pulse_vsync(8);
    rdc(REG_BLINK, 32'h0000_0008);
    show(8'h0f, 4'h3, CHR, 3'h6, 8'hf0, 2'h1);
    show(8'ha5, 4'h3, CHR | BLNK, NORM, 8'ha5, 2'h0);
    ctl.pulse_vsync(8);
    show(8'h0f, 4'h3, CHR, 3'h6, 8'h0f, 2'h0);
    show(8'ha5, 4'h3, CHR | BLNK, NORM, 8'ha5, 2'h0);
    ctl.pulse_vsync(8);
    show(8'ha5, 4'h3, CHR | BLNK, NORM, 8'h00, 2'h0);
    show(8'ha5, 4'h3, CHR | BLNK, 3'h6, 8'hff, 2'h1);
    rdc(REG_STATUS, 32'h0000_0003);
    ctl.pulse_vsync(8);
    rdc(REG_BLINK, 32'h0000_0000);
  endtask

  // loads closer than the character rate allows set the sticky error
  task automatic test_rate_limit;
    ctl.run_slot(8'h00, 4'h0, CHR, NORM, 5, 20);
    ctl.run_slot(8'h00, 4'h0, CHR, NORM, 5, 20);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    check({31'h0000_0000, rv[ST_RATE_ERR]}, 32'h0000_0001);
    bus(1'b1, REG_STATUS, 32'h0000_0008);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    check({31'h0000_0000, rv[ST_RATE_ERR]}, 32'h0000_0000);
    // a load too short to meet a dot enable pushes without a pop, so the buffer fills
    ctl.run_slot(8'h00, 4'h0, CHR, NORM, 3, 60);
    bus(1'b0, REG_STATUS, 32'h0000_0000);
    check({31'h0000_0000, rv[ST_BUF_FULL]}, 32'h0000_0001);
  endtask

  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog against a hung handshake or slot
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    test_calibrate();
    test_registers();
    test_modes();
    test_attributes();
    test_blink_cursor();
    test_rate_limit();
    finish_test();
  end
endmodule // tb
`default_nettype wire
